// ==== hdl/tcc_pkg.sv ====
// Package for the 16-bit timer/counter with input capture
`default_nettype none
package tcc_pkg;
	// Register offsets on the 8-bit plain port
	localparam logic [3:0] ADDR_CTRL_FIRST   = 4'h0;
	localparam logic [3:0] ADDR_CTRL_SECOND  = 4'h1;
	localparam logic [3:0] ADDR_COUNT_LOW    = 4'h2;
	localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h3;
	localparam logic [3:0] ADDR_CAPTURE_LOW  = 4'h4;
	localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h5;
	localparam logic [3:0] ADDR_CMPA_LOW     = 4'h6;
	localparam logic [3:0] ADDR_CMPA_HIGH    = 4'h7;
	localparam logic [3:0] ADDR_CMPB_LOW     = 4'h8;
	localparam logic [3:0] ADDR_CMPB_HIGH    = 4'h9;
	localparam logic [3:0] ADDR_FLAGS        = 4'hA;
	localparam logic [3:0] ADDR_IRQ_ENABLE   = 4'hB;
	localparam logic [3:0] ADDR_COMP_CTRL    = 4'hC;
	// Field positions
	localparam int CF_WGM_LO  = 0;
	localparam int CS_CLK_LO  = 0;
	localparam int CS_WGM_HI  = 3;
	localparam int CS_EDGE    = 6;
	localparam int CS_FILTER  = 7;
	localparam int FL_OVF     = 0;
	localparam int FL_CAPTURE = 1;
	localparam int CC_SELECT  = 0;
	// Clock select codes
	localparam logic [2:0] CLK_STOP     = 3'h0;
	localparam logic [2:0] CLK_EXT_FALL = 3'h6;
	localparam logic [2:0] CLK_EXT_RISE = 3'h7;
	// Fixed values
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT     = 16'h00FF;
	localparam logic [15:0] TOP_9BIT     = 16'h01FF;
	localparam logic [15:0] TOP_10BIT    = 16'h03FF;
	localparam int FILTER_SAMPLES = 4;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef struct packed {
		logic [15:0] count_value;
		logic [15:0] capture_value;
		logic [15:0] cmpa;
		logic [15:0] cmpb;
		logic [7:0]  hold_byte;
		logic [7:0]  ctrl_first;
		logic [7:0]  ctrl_second;
		logic [1:0]  flags;
		logic [1:0]  irq_enable;
		logic        comparator_capture_select;
		logic        count_down;
		logic [2:0]  ext_sync;
		logic [1:0]  cap_sync;
		logic [FILTER_SAMPLES-1:0] filt_hist;
		logic        filt_out;
		logic        edge_prev;
		logic [7:0]  rdata;
		logic        overflow_irq;
		logic        capture_irq;
	} tcc_state_t;
endpackage : tcc_pkg
`default_nettype wire

// ==== hdl/tcc_timer.sv ====
// 16-bit timer/counter with shared high-byte register and input capture
//
// Function
// - Count high byte goes through holding register; low byte access moves it.
// - 16-bit up/down counter, steps by one or clears, flags top and zero.
// - Counter clears, increments or decrements once per timer tick per mode.
// - Clock select zero stops counting; counter remains readable and writable.
// - CPU write to the counter beats any clear or count that cycle.
// - Timer tick from prescaled or external source, chosen by clock select.
// - Four-bit waveform mode, split over both control registers, sets sequence.
// - Overflow flag set where the waveform mode says; may request interrupt.
// - Qualifying edge on capture source copies whole counter to capture value.
// - Capture flag set with the copy; requests interrupt when enabled.
// - Capture flag clears on interrupt service or on writing one.
// - Capture low read copies capture high into holding register.
// - Capture register writable only in modes using it as top.
// - Comparator select bit switches capture source to comparator output.
// - Capture pin and comparator synchronised and edge detected like clock pin.
// - Filter output changes only after four equal consecutive samples.
// - Filter enable bit inserts filter; four system clocks of latency.
// - Filter and edge inputs active except in capture-as-top modes.
// - Port output driving the capture pin can trigger a capture.
// - Every qualifying event overwrites the capture value.
// - One high-byte write may serve several later low-byte writes.
// - Low-byte write loads held high byte and low byte in one cycle.
// - Compare register reads return both bytes directly.
// - Bottom at zero, maximum at all ones.
//
// Our own choices: strobed register access and the register addresses.
`default_nettype none
module tcc_timer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic       prescale_tick,
	input  wire logic       external_clock_pin,
	input  wire logic       capture_pin,
	input  wire logic       comparator_output,
	input  wire logic       overflow_irq_ack,
	input  wire logic       capture_irq_ack,
	output logic [7:0]      rdata,
	output logic [15:0]     count_value,
	output logic            overflow_irq,
	output logic            capture_irq
);
	tcc_pkg::tcc_state_t s, next_s;

	logic [3:0]  mode;
	logic [2:0]  clk_sel;
	logic        timer_tick;
	logic [15:0] top;
	logic        dual_slope;
	logic        icr_is_top;
	logic        at_top;
	logic        at_bottom;
	logic        at_max;
	logic        cap_src;
	logic        edge_in;
	logic        cap_event;
	logic        ovf_event;
	logic [15:0] next_count;
	logic        next_down;

	assign mode    = {s.ctrl_second[tcc_pkg::CS_WGM_HI+1 -: 2], s.ctrl_first[tcc_pkg::CF_WGM_LO+1 -: 2]};
	assign clk_sel = s.ctrl_second[tcc_pkg::CS_CLK_LO+2 -: 3];

	////////////////////////////////////////////////////////////////////////////
	// Tick selection and mode decode
	always_comb begin
		case (clk_sel)
			tcc_pkg::CLK_STOP:     timer_tick = 1'b0;
			tcc_pkg::CLK_EXT_FALL: timer_tick = s.ext_sync[2] & ~s.ext_sync[1];
			tcc_pkg::CLK_EXT_RISE: timer_tick = ~s.ext_sync[2] & s.ext_sync[1];
			default:               timer_tick = prescale_tick;
		endcase
		dual_slope = 1'b0;
		icr_is_top = 1'b0;
		case (mode)
			4'h1: begin top = tcc_pkg::TOP_8BIT; dual_slope = 1'b1; end
			4'h2: begin top = tcc_pkg::TOP_9BIT; dual_slope = 1'b1; end
			4'h3: begin top = tcc_pkg::TOP_10BIT; dual_slope = 1'b1; end
			4'h4: top = s.cmpa;
			4'h5: top = tcc_pkg::TOP_8BIT;
			4'h6: top = tcc_pkg::TOP_9BIT;
			4'h7: top = tcc_pkg::TOP_10BIT;
			4'h8: begin top = s.capture_value; dual_slope = 1'b1; icr_is_top = 1'b1; end
			4'h9: begin top = s.cmpa; dual_slope = 1'b1; end
			4'hA: begin top = s.capture_value; dual_slope = 1'b1; icr_is_top = 1'b1; end
			4'hB: begin top = s.cmpa; dual_slope = 1'b1; end
			4'hC: begin top = s.capture_value; icr_is_top = 1'b1; end
			4'hE: begin top = s.capture_value; icr_is_top = 1'b1; end
			4'hF: top = s.cmpa;
			default: top = tcc_pkg::COUNT_MAX;
		endcase
	end

	assign at_bottom = (s.count_value == tcc_pkg::COUNT_BOTTOM);
	assign at_max    = (s.count_value == tcc_pkg::COUNT_MAX);
	assign at_top    = (s.count_value == top) || at_max;

	////////////////////////////////////////////////////////////////////////////
	// Counter step
	always_comb begin
		next_count = s.count_value;
		next_down  = s.count_down;
		ovf_event  = 1'b0;
		if (timer_tick) begin
			if (dual_slope) begin
				if (s.count_down) begin
					if (at_bottom) begin
						next_count = s.count_value + 16'h0001;
						next_down  = 1'b0;
						ovf_event  = 1'b1;
					end else begin
						next_count = s.count_value - 16'h0001;
					end
				end else if (at_top) begin
					next_count = s.count_value - 16'h0001;
					next_down  = 1'b1;
				end else begin
					next_count = s.count_value + 16'h0001;
				end
			end else begin
				next_down = 1'b0;
				if (at_top) begin
					next_count = tcc_pkg::COUNT_BOTTOM;
					ovf_event  = (mode != 4'h4) && (mode != 4'hC) ? 1'b1 : at_max;
				end else begin
					next_count = s.count_value + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture source, filter and edge detect
	assign cap_src = s.comparator_capture_select ? comparator_output : capture_pin;
	assign edge_in = s.ctrl_second[tcc_pkg::CS_FILTER] ? s.filt_out : s.cap_sync[1];
	// Edge qualified on the stage after the second synchroniser flop, or after the filter output when filter enable is set
	assign cap_event = !icr_is_top &&
		(s.ctrl_second[tcc_pkg::CS_EDGE] ? (edge_in & ~s.edge_prev) : (~edge_in & s.edge_prev));

	////////////////////////////////////////////////////////////////////////////
	// Next-state
	always_comb begin
		next_s = s;
		next_s.ext_sync  = {s.ext_sync[1:0], external_clock_pin};
		next_s.cap_sync  = {s.cap_sync[0], cap_src};
		next_s.filt_hist = {s.filt_hist[tcc_pkg::FILTER_SAMPLES-2:0], s.cap_sync[1]};
		// Judged on the history including this sample, so latency is exactly four
		if (&next_s.filt_hist) begin
			next_s.filt_out = 1'b1;
		end else if (~|next_s.filt_hist) begin
			next_s.filt_out = 1'b0;
		end
		next_s.edge_prev  = edge_in;
		next_s.count_value = next_count;
		next_s.count_down  = next_down;
		next_s.rdata       = tcc_pkg::BYTE_ZERO;

		// Clears first so that a same-cycle hardware set wins below
		if (overflow_irq_ack) begin
			next_s.flags[tcc_pkg::FL_OVF] = 1'b0;
		end
		if (capture_irq_ack) begin
			next_s.flags[tcc_pkg::FL_CAPTURE] = 1'b0;
		end

		if (rd) begin
			case (addr)
				tcc_pkg::ADDR_CTRL_FIRST:   next_s.rdata = s.ctrl_first;
				tcc_pkg::ADDR_CTRL_SECOND:  next_s.rdata = s.ctrl_second;
				tcc_pkg::ADDR_COUNT_LOW: begin
					next_s.rdata     = s.count_value[7:0];
					next_s.hold_byte = s.count_value[15:8];
				end
				tcc_pkg::ADDR_CAPTURE_LOW: begin
					next_s.rdata     = s.capture_value[7:0];
					next_s.hold_byte = s.capture_value[15:8];
				end
				tcc_pkg::ADDR_COUNT_HIGH:   next_s.rdata = s.hold_byte;
				tcc_pkg::ADDR_CAPTURE_HIGH: next_s.rdata = s.hold_byte;
				tcc_pkg::ADDR_CMPA_LOW:     next_s.rdata = s.cmpa[7:0];
				tcc_pkg::ADDR_CMPA_HIGH:    next_s.rdata = s.cmpa[15:8];
				tcc_pkg::ADDR_CMPB_LOW:     next_s.rdata = s.cmpb[7:0];
				tcc_pkg::ADDR_CMPB_HIGH:    next_s.rdata = s.cmpb[15:8];
				tcc_pkg::ADDR_FLAGS:        next_s.rdata = {6'h00, s.flags};
				tcc_pkg::ADDR_IRQ_ENABLE:   next_s.rdata = {6'h00, s.irq_enable};
				tcc_pkg::ADDR_COMP_CTRL:    next_s.rdata = {7'h00, s.comparator_capture_select};
				default:                    next_s.rdata = tcc_pkg::BYTE_ZERO;
			endcase
		end

		if (wr) begin
			case (addr)
				tcc_pkg::ADDR_CTRL_FIRST:   next_s.ctrl_first  = wdata;
				tcc_pkg::ADDR_CTRL_SECOND:  next_s.ctrl_second = wdata;
				tcc_pkg::ADDR_COUNT_HIGH,
				tcc_pkg::ADDR_CAPTURE_HIGH,
				tcc_pkg::ADDR_CMPA_HIGH,
				tcc_pkg::ADDR_CMPB_HIGH:    next_s.hold_byte = wdata;
				tcc_pkg::ADDR_COUNT_LOW:    next_s.count_value = {s.hold_byte, wdata};
				tcc_pkg::ADDR_CAPTURE_LOW: begin
					if (icr_is_top) begin
						next_s.capture_value = {s.hold_byte, wdata};
					end
				end
				tcc_pkg::ADDR_CMPA_LOW:     next_s.cmpa = {s.hold_byte, wdata};
				tcc_pkg::ADDR_CMPB_LOW:     next_s.cmpb = {s.hold_byte, wdata};
				tcc_pkg::ADDR_FLAGS: begin
					if (wdata[tcc_pkg::FL_OVF]) begin
						next_s.flags[tcc_pkg::FL_OVF] = 1'b0;
					end
					if (wdata[tcc_pkg::FL_CAPTURE]) begin
						next_s.flags[tcc_pkg::FL_CAPTURE] = 1'b0;
					end
				end
				tcc_pkg::ADDR_IRQ_ENABLE:   next_s.irq_enable = wdata[1:0];
				tcc_pkg::ADDR_COMP_CTRL:    next_s.comparator_capture_select = wdata[tcc_pkg::CC_SELECT];
				default: ;
			endcase
		end

		if (ovf_event) begin
			next_s.flags[tcc_pkg::FL_OVF] = 1'b1;
		end
		if (cap_event) begin
			next_s.capture_value = s.count_value;
			next_s.flags[tcc_pkg::FL_CAPTURE] = 1'b1;
		end
		next_s.overflow_irq = next_s.flags[tcc_pkg::FL_OVF] & next_s.irq_enable[tcc_pkg::FL_OVF];
		next_s.capture_irq  = next_s.flags[tcc_pkg::FL_CAPTURE] & next_s.irq_enable[tcc_pkg::FL_CAPTURE];
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata        = s.rdata;
	assign count_value  = s.count_value;
	assign overflow_irq = s.overflow_irq;
	assign capture_irq  = s.capture_irq;
endmodule : tcc_timer
`default_nettype wire

// ==== sim/tb_tcc_timer.sv ====
// Self-checking bench for the timer/counter
`default_nettype none
module tb_tcc_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, prescale_tick = 1'b0, capture_pin = 1'b0, comparator_output = 1'b0;
	logic        overflow_irq_ack = 1'b0, capture_irq_ack = 1'b0, wr, rd, overflow_irq, capture_irq;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [15:0] count_value, v;
	int          errors = 0, checks = 0, n0, n1;
	always #2 clk = ~clk;
	tcc_timer i_tcc_timer (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.prescale_tick(prescale_tick), .external_clock_pin(1'b0), .capture_pin(capture_pin),
		.comparator_output(comparator_output), .overflow_irq_ack(overflow_irq_ack),
		.capture_irq_ack(capture_irq_ack), .rdata(rdata), .count_value(count_value),
		.overflow_irq(overflow_irq), .capture_irq(capture_irq));
	tcc_cpu_model i_tcc_cpu_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk) prescale_tick <= 1'b1;
			@(posedge clk) prescale_tick <= 1'b0;
		end
		@(posedge clk) #1;
	endtask : tick
	// Bounded wait; a wanted capture that never comes ends the run
	task automatic drive_src(input logic cmp, input logic val, input logic want, output int n);
		@(posedge clk);
		if (cmp) comparator_output <= val;
		else capture_pin <= val;
		n = 0;
		do begin
			@(posedge clk) #1;
			n++;
		end while (capture_irq !== 1'b1 && n < 16);
		if (want && capture_irq !== 1'b1) begin
			errors++;
			$display("Error at %0t: capture wait ran out", $time);
			tally_and_finish();
		end
	endtask : drive_src
	task automatic ack();
		@(posedge clk) capture_irq_ack <= 1'b1;
		@(posedge clk) capture_irq_ack <= 1'b0;
		@(posedge clk) #1;
		check(capture_irq, 16'h0000);
	endtask : ack
	////////////////////////////////////////////////////////////////////////
	task automatic t_bytes();
		i_tcc_cpu_model.put16(tcc_pkg::ADDR_COUNT_HIGH, 16'h1234);
		tick(3);
		check(count_value, 16'h1234);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_COUNT_HIGH, v);
		check(v, 16'h1234);
		i_tcc_cpu_model.put(4'hF, 8'hFF);
		i_tcc_cpu_model.get16(4'hF, v);
		check(v, 16'h0000);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CMPA_HIGH, 8'hAB);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CMPA_LOW, 8'h01);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CMPB_LOW, 8'h02);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_CMPB_HIGH, v);
		check(v, 16'hAB02);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_COUNT_HIGH, v);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_CMPA_HIGH, v);
		check(v, 16'hAB01);
		$display("bytes test done");
	endtask : t_bytes
	task automatic t_count();
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CTRL_SECOND, 8'h01);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_IRQ_ENABLE, 8'h01);
		i_tcc_cpu_model.put16(tcc_pkg::ADDR_COUNT_HIGH, 16'hFFFE);
		tick(2);
		check(count_value, 16'h0000);
		check(overflow_irq, 16'h0001);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_FLAGS, 8'h01);
		@(posedge clk) #1;
		check(overflow_irq, 16'h0000);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_COUNT_HIGH, 8'h00);
		fork
			i_tcc_cpu_model.put(tcc_pkg::ADDR_COUNT_LOW, 8'h50);
			tick(1);
		join
		check(count_value, 16'h0050);
		$display("count test done");
	endtask : t_count
	task automatic t_capture();
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CTRL_SECOND, 8'h40);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_IRQ_ENABLE, 8'h02);
		i_tcc_cpu_model.put16(tcc_pkg::ADDR_COUNT_HIGH, 16'h0055);
		drive_src(1'b0, 1'b1, 1'b1, n0);
		check(capture_irq, 16'h0001);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_CAPTURE_HIGH, v);
		check(v, 16'h0055);
		ack();
		i_tcc_cpu_model.put16(tcc_pkg::ADDR_COUNT_HIGH, 16'h0066);
		drive_src(1'b0, 1'b0, 1'b0, n1);
		check(capture_irq, 16'h0000);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CTRL_SECOND, 8'hC0);
		drive_src(1'b0, 1'b1, 1'b1, n1);
		check(16'(n1), 16'(n0 + 4));
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_CAPTURE_HIGH, v);
		check(v, 16'h0066);
		ack();
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CTRL_SECOND, 8'h80);
		@(posedge clk) capture_pin <= 1'b0;
		repeat (2) @(posedge clk);
		capture_pin <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		check(capture_irq, 16'h0000);
		// Switching the source may capture, so the flag is cleared after
		i_tcc_cpu_model.put(tcc_pkg::ADDR_COMP_CTRL, 8'h01);
		repeat (10) @(posedge clk);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CTRL_SECOND, 8'h40);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_FLAGS, 8'h02);
		@(posedge clk) #1;
		check(capture_irq, 16'h0000);
		drive_src(1'b1, 1'b1, 1'b1, n1);
		check(capture_irq, 16'h0001);
		ack();
		i_tcc_cpu_model.put16(tcc_pkg::ADDR_CAPTURE_HIGH, 16'h7777);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_CAPTURE_HIGH, v);
		check(v, 16'h0066);
		i_tcc_cpu_model.put(tcc_pkg::ADDR_CTRL_SECOND, 8'h18);
		i_tcc_cpu_model.put16(tcc_pkg::ADDR_CAPTURE_HIGH, 16'h7777);
		i_tcc_cpu_model.get16(tcc_pkg::ADDR_CAPTURE_HIGH, v);
		check(v, 16'h7777);
		$display("capture test done");
	endtask : t_capture
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_bytes();
		t_count();
		t_capture();
		tally_and_finish();
	end
endmodule : tb_tcc_timer
`default_nettype wire

// ==== sim/tcc_cpu_model.sv ====
// CPU core side of the 8-bit register port
`default_nettype none
module tcc_cpu_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic [3:0]      addr,
	output logic [7:0]      wdata,
	output logic            wr,
	output logic            rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {addr, wdata, wr, rd} = 14'h0000;
	// Released lines show inverted values so stale data never looks valid
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask : put
	task automatic get(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask : get
	// Pairs never interleave, so the shared high byte is never stolen
	task automatic put16(input logic [3:0] a_hi, input logic [15:0] v);
		put(a_hi, v[15:8]);
		put(a_hi - 4'h1, v[7:0]);
	endtask : put16
	task automatic get16(input logic [3:0] a_hi, output logic [15:0] v);
		get(a_hi - 4'h1, v[7:0]);
		get(a_hi, v[15:8]);
	endtask : get16
endmodule : tcc_cpu_model
`default_nettype wire

// ==== sim/tcc_timer_properties.sv ====
// Port-level assertions for the timer/counter
`default_nettype none
module tcc_timer_properties (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic        prescale_tick,
	input wire logic        overflow_irq_ack,
	input wire logic [7:0]  rdata,
	input wire logic [15:0] count_value,
	input wire logic        overflow_irq,
	input wire logic        capture_irq
);
	logic [7:0] cf, cs2;
	logic [1:0] ien;
	logic       norm, run, lw;
	// Shadow copies of the control bytes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cf <= 8'h00;
			cs2 <= 8'h00;
			ien <= 2'h0;
		end else if (wr) begin
			if (addr == tcc_pkg::ADDR_CTRL_FIRST) cf <= wdata;
			if (addr == tcc_pkg::ADDR_CTRL_SECOND) cs2 <= wdata;
			if (addr == tcc_pkg::ADDR_IRQ_ENABLE) ien <= wdata[1:0];
		end
	end
	assign norm = cf[1:0] == 2'h0 && cs2[4:3] == 2'h0;
	assign run = cs2[2:0] inside {[3'h1:3'h5]};
	assign lw = wr && addr == tcc_pkg::ADDR_COUNT_LOW;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence low_rd; rd && addr == tcc_pkg::ADDR_COUNT_LOW; endsequence
	sequence high_rd; rd && addr == tcc_pkg::ADDR_COUNT_HIGH; endsequence
	////////////////////////////////////////////////////////////////////////
	count_low_read_a: assert property (low_rd |=> rdata == $past(count_value[7:0]))
		else $error("count low read wrong");
	count_pair_read_a: assert property (low_rd ##1 high_rd |=> rdata == $past(count_value[15:8], 2))
		else $error("count high read not from held byte");
	count_write_a: assert property (lw |=> count_value[7:0] == $past(wdata))
		else $error("count low write lost");
	stopped_hold_a: assert property (cs2[2:0] == tcc_pkg::CLK_STOP && !lw |=> $stable(count_value))
		else $error("counter moved while stopped");
	tick_step_a: assert property (run && norm && prescale_tick && !lw |=> count_value == $past(count_value) + 16'h0001)
		else $error("counter did not step on tick");
	no_tick_hold_a: assert property (run && !prescale_tick && !lw |=> $stable(count_value))
		else $error("counter moved without tick");
	overflow_set_a: assert property (run && norm && ien[0] && prescale_tick && !wr && !overflow_irq_ack
		&& count_value == tcc_pkg::COUNT_MAX |=> ##[0:1] overflow_irq)
		else $error("overflow not flagged at max");
	capture_enable_a: assert property (capture_irq |-> ien[1] || $past(ien[1]))
		else $error("capture request while disabled");
endmodule : tcc_timer_properties
bind tcc_timer tcc_timer_properties i_tcc_timer_properties (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .prescale_tick(prescale_tick), .overflow_irq_ack(overflow_irq_ack),
	.rdata(rdata), .count_value(count_value), .overflow_irq(overflow_irq), .capture_irq(capture_irq));
`default_nettype wire
